// *** design/etrf_pkg.sv ***
// etrf_pkg: constants and types of the ethernet mac transmit and receive fifo block
package etrf_pkg;

  // ==========================================================
  // timing
  localparam longint CLK_KHZ     = 40000;
  localparam longint NS_PER_MS   = 1000000;
  localparam longint IFG_NS      = 9600;
  localparam longint IFG_OPEN_NS = 6400;
  localparam longint SLOT_NS     = 51200;
  localparam int IFG_CYC      = int'((IFG_NS * CLK_KHZ + NS_PER_MS - 1) / NS_PER_MS);
  localparam int IFG_OPEN_CYC = int'((IFG_OPEN_NS * CLK_KHZ + NS_PER_MS - 1) / NS_PER_MS);
  localparam int SLOT_CYC     = int'((SLOT_NS * CLK_KHZ + NS_PER_MS - 1) / NS_PER_MS);
  localparam logic [8:0]  IFG_LAST  = 9'(IFG_CYC - 1);
  localparam logic [8:0]  IFG_OPEN  = 9'(IFG_OPEN_CYC);
  localparam logic [10:0] SLOT_LAST = 11'(SLOT_CYC - 1);

  // ==========================================================
  // framing and protocol
  localparam logic [2:0]  PRE_LAST     = 3'h6;
  localparam logic [2:0]  SFD_INDEX    = 3'h7;
  localparam logic [7:0]  PRE_BYTE     = 8'h55;
  localparam logic [7:0]  SFD_BYTE     = 8'hd5;
  localparam logic [5:0]  BYTE_LAST    = 6'h07;
  localparam logic [5:0]  JAM_LAST     = 6'h1f;
  localparam logic [5:0]  FCS_LAST     = 6'h1f;
  localparam logic [31:0] CRC_POLY     = 32'hedb88320;
  localparam logic [31:0] CRC_INIT     = 32'hffffffff;
  localparam logic [4:0]  MAX_ATTEMPTS = 5'h10;
  localparam logic [4:0]  BACKOFF_CAP  = 5'h0a;
  localparam logic [15:0] LFSR_SEED    = 16'hace1;

  // ==========================================================
  // receive fifo
  localparam logic [7:0] FILL_BYTE  = 8'hff;
  localparam logic [5:0] FIFO_BYTES = 6'h20;
  localparam logic [5:0] UNIT32     = 6'h04;
  localparam logic [5:0] UNIT16     = 6'h02;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    TX_IDLE, TX_IFG, TX_PRE, TX_DATA, TX_FCS, TX_JAM, TX_TAIL, TX_BACKOFF
  } etrf_tx_state_t;
  typedef enum logic [1:0] {RX_DATA, RX_PAD, RX_STAT} etrf_rx_state_t;
  typedef enum logic [1:0] {DMA_IDLE, DMA_WAIT, DMA_MOVE} etrf_dma_state_t;

  typedef struct packed {
    logic       done;
    logic       ok;
    logic       excessColl;
    logic [4:0] collisions;
  } etrf_tx_status_t;

  typedef struct packed {
    logic        req;
    logic        valid;
    logic        last;
    logic [31:0] data;
  } etrf_dma_out_t;

  typedef struct packed {
    etrf_tx_state_t       txState;
    logic                 oscPhase;
    logic                 txcPhase;
    logic                 txSerial;
    logic                 txEnable;
    logic                 txTake;
    logic                 txRewind;
    logic [8:0]           ifgCnt;
    logic [10:0]          slotCnt;
    logic [10:0]          slotsLeft;
    logic [7:0]           shifter;
    logic [5:0]           bitCnt;
    logic [2:0]           byteCnt;
    logic                 lastByte;
    logic                 preColl;
    logic                 jammed;
    logic [4:0]           attempts;
    logic [31:0]          crc;
    logic [15:0]          lfsr;
    etrf_tx_status_t      txStatus;
    etrf_rx_state_t       rxState;
    logic [15:0]          rxStat;
    logic [5:0]           wrPtr;
    logic [5:0]           rdPtr;
    logic [7:0][3:0][7:0] mem;
    logic                 flush;
    etrf_dma_state_t      dmaState;
    logic [5:0]           burstLeft;
    etrf_dma_out_t        dma;
  } etrf_state_t;

endpackage

// *** design/etrf_mac.sv ***
// etrf_mac: ethernet mac transmit sequencer, crc, backoff and receive fifo with dma unload
`timescale 1ns/1ps
`default_nettype none

module etrf_mac
  import etrf_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // configuration
  input  wire logic        dataWidthSelect,
  input  wire logic        byteOrderSelect,
  input  wire logic        burstModeSelect,
  input  wire logic [1:0]  rxFifoThreshold,
  input  wire logic        crcInhibit,
  // network side
  input  wire logic        carrierSense,
  input  wire logic        collision,
  output logic             transmitBitClock,
  output logic             txSerial,
  output logic             txEnable,
  // transmit byte source
  input  wire logic        txStart,
  input  wire logic [7:0]  txData,
  input  wire logic        txLast,
  output logic             txTake,
  output logic             txRewind,
  output etrf_tx_status_t  txStatus,
  // receive byte sink
  input  wire logic        rxByteValid,
  input  wire logic [7:0]  rxByte,
  input  wire logic        rxEnd,
  input  wire logic [15:0] rxStatus,
  // receive dma
  input  wire logic        rxDmaGrant,
  output etrf_dma_out_t    rxDma
);
  // ==========================================================
  // helpers
  function automatic logic [1:0] laneOf(logic [1:0] p, logic big, logic wide);
    if (!big)
      return p;
    else if (wide)
      return ~p;
    else
      return {p[1], ~p[0]};
  endfunction
  function automatic logic [10:0] backoffSlots(logic [4:0] n, logic [15:0] rnd);
    logic [4:0]  k;
    logic [10:0] mask;
    k    = (n > BACKOFF_CAP) ? BACKOFF_CAP : n;
    mask = (11'h001 << k) - 11'h001;
    return (rnd[10:0] & mask) + {10'h000, rnd[15]};
  endfunction
  // ==========================================================
  // reset release
  logic [1:0]  rstSync;
  logic        rstN;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      rstSync <= 2'h0;
    else
      rstSync <= {rstSync[0], 1'b1};
  end
  assign rstN = rstSync[1];
  // ==========================================================
  // state
  etrf_state_t st_reg;
  etrf_state_t st_next;
  logic        bitTick;
  logic [5:0]  unit;
  logic [5:0]  count;
  logic [5:0]  aligned;
  logic [5:0]  thr;
  logic        full;
  logic [4:0]  att;
  logic [10:0] slots;
  logic [1:0]  wrLane;
  logic [31:0] rdWord;
  always_comb begin
    st_next = st_reg;
    att     = st_reg.attempts + 5'h01;
    slots   = backoffSlots(att, st_reg.lfsr);
    unit    = dataWidthSelect ? UNIT32 : UNIT16;
    count   = st_reg.wrPtr - st_reg.rdPtr;
    aligned = count & ~(unit - 6'h01);
    thr     = {1'b0, 3'({1'b0, rxFifoThreshold} + 3'h1), 2'h0};
    full    = (count == FIFO_BYTES);
    wrLane  = laneOf(st_reg.wrPtr[1:0], byteOrderSelect, dataWidthSelect);
    rdWord  = st_reg.mem[st_reg.rdPtr[4:2]];
    // bit clock: 40 MHz halved to the oscillator rate, then halved again
    st_next.oscPhase = ~st_reg.oscPhase;
    if (st_reg.oscPhase)
      st_next.txcPhase = ~st_reg.txcPhase;
    bitTick = st_reg.oscPhase & st_reg.txcPhase;
    st_next.lfsr = {st_reg.lfsr[14:0],
                    st_reg.lfsr[15] ^ st_reg.lfsr[13] ^ st_reg.lfsr[12] ^ st_reg.lfsr[10]};
    st_next.txTake        = 1'b0;
    st_next.txRewind      = 1'b0;
    st_next.txStatus.done = 1'b0;
    // ========================================================
    // transmit sequencer
    unique case (st_reg.txState)
      TX_IDLE: begin
        if (txStart) begin
          st_next.txState  = TX_IFG;
          st_next.ifgCnt   = '0;
          st_next.attempts = '0;
        end
      end
      TX_IFG: begin
        // late activity is ignored so a busy wire cannot starve the last 3.2 us
        if ((carrierSense | collision) && st_reg.ifgCnt < IFG_OPEN) begin
          st_next.ifgCnt = '0;
        end else if (st_reg.ifgCnt == IFG_LAST) begin
          st_next.txState = TX_PRE;
          st_next.byteCnt = '0;
          st_next.bitCnt  = '0;
          st_next.shifter = PRE_BYTE;
          st_next.preColl = 1'b0;
          st_next.jammed  = 1'b0;
          st_next.crc     = CRC_INIT;
        end else begin
          st_next.ifgCnt = st_reg.ifgCnt + 9'h001;
        end
      end
      TX_PRE: begin
        if (collision)
          st_next.preColl = 1'b1;
        if (bitTick) begin
          st_next.txEnable = 1'b1;
          st_next.txSerial = st_reg.shifter[0];
          st_next.shifter  = st_reg.shifter >> 1;
          st_next.bitCnt   = st_reg.bitCnt + 6'h01;
          if (st_reg.bitCnt == BYTE_LAST) begin
            st_next.bitCnt  = '0;
            st_next.byteCnt = st_reg.byteCnt + 3'h1;
            st_next.shifter = (st_reg.byteCnt == PRE_LAST) ? SFD_BYTE : PRE_BYTE;
            if (st_reg.byteCnt == SFD_INDEX) begin
              if (st_reg.preColl | collision) begin
                st_next.txState = TX_JAM;
                st_next.jammed  = 1'b1;
              end else begin
                st_next.txState  = TX_DATA;
                st_next.shifter  = txData;
                st_next.lastByte = txLast;
                st_next.txTake   = 1'b1;
              end
            end
          end
        end
      end
      TX_DATA, TX_FCS: begin
        if (collision) begin
          st_next.txState = TX_JAM;
          st_next.jammed  = 1'b1;
          st_next.bitCnt  = '0;
        end else if (bitTick && st_reg.txState == TX_DATA) begin
          st_next.txSerial = st_reg.shifter[0];
          st_next.crc      = (st_reg.crc >> 1) ^
                             ((st_reg.crc[0] ^ st_reg.shifter[0]) ? CRC_POLY : '0);
          st_next.shifter  = st_reg.shifter >> 1;
          st_next.bitCnt   = st_reg.bitCnt + 6'h01;
          if (st_reg.bitCnt == BYTE_LAST) begin
            st_next.bitCnt = '0;
            if (st_reg.lastByte) begin
              st_next.txState = crcInhibit ? TX_TAIL : TX_FCS;
            end else begin
              st_next.shifter  = txData;
              st_next.lastByte = txLast;
              st_next.txTake   = 1'b1;
            end
          end
        end else if (bitTick) begin
          st_next.txSerial = ~st_reg.crc[0];
          st_next.crc      = st_reg.crc >> 1;
          st_next.bitCnt   = st_reg.bitCnt + 6'h01;
          if (st_reg.bitCnt == FCS_LAST)
            st_next.txState = TX_TAIL;
        end
      end
      TX_JAM: begin
        if (bitTick) begin
          st_next.txEnable = 1'b1;
          st_next.txSerial = 1'b1;
          st_next.bitCnt   = st_reg.bitCnt + 6'h01;
          if (st_reg.bitCnt == JAM_LAST)
            st_next.txState = TX_TAIL;
        end
      end
      TX_TAIL: begin
        if (bitTick) begin
          st_next.txEnable = 1'b0;
          st_next.txSerial = 1'b0;
          st_next.txState  = TX_IDLE;
          if (!st_reg.jammed) begin
            st_next.txStatus = '{done: 1'b1, ok: 1'b1, excessColl: 1'b0,
                                 collisions: st_reg.attempts};
          end else if (att == MAX_ATTEMPTS) begin
            st_next.txStatus = '{done: 1'b1, ok: 1'b0, excessColl: 1'b1,
                                 collisions: att};
          end else begin
            st_next.attempts  = att;
            st_next.txRewind  = 1'b1;
            st_next.slotsLeft = slots;
            st_next.slotCnt   = '0;
            st_next.ifgCnt    = '0;
            st_next.txState   = (slots == '0) ? TX_IFG : TX_BACKOFF;
          end
        end
      end
      TX_BACKOFF: begin
        st_next.slotCnt = st_reg.slotCnt + 11'h001;
        if (st_reg.slotCnt == SLOT_LAST) begin
          st_next.slotCnt   = '0;
          st_next.slotsLeft = st_reg.slotsLeft - 11'h001;
          if (st_reg.slotsLeft == 11'h001)
            st_next.txState = TX_IFG;
        end
      end
    endcase
    // ========================================================
    // receive dma unload; runs before the fill side so a fresh flush wins
    st_next.dma.valid = 1'b0;
    st_next.dma.last  = 1'b0;
    unique case (st_reg.dmaState)
      DMA_IDLE: begin
        if (count > thr || (st_reg.flush && aligned != '0)) begin
          st_next.dma.req  = 1'b1;
          st_next.dmaState = DMA_WAIT;
        end
      end
      DMA_WAIT: begin
        if (rxDmaGrant) begin
          st_next.burstLeft = (burstModeSelect && !st_reg.flush) ? thr : aligned;
          st_next.flush     = 1'b0;
          st_next.dmaState  = DMA_MOVE;
        end
      end
      DMA_MOVE: begin
        st_next.dma.valid = 1'b1;
        if (dataWidthSelect)
          st_next.dma.data = rdWord;
        else
          st_next.dma.data = {16'h0000, rdWord[{st_reg.rdPtr[1], 4'h0} +: 16]};
        st_next.rdPtr     = st_reg.rdPtr + unit;
        st_next.burstLeft = st_reg.burstLeft - unit;
        if (st_reg.burstLeft == unit) begin
          st_next.dma.last = 1'b1;
          st_next.dma.req  = 1'b0;
          st_next.dmaState = DMA_IDLE;
        end
      end
      default: st_next.dmaState = DMA_IDLE;
    endcase
    // ========================================================
    // receive fifo fill
    unique case (st_reg.rxState)
      RX_DATA: begin
        // a byte that meets a full fifo is dropped; the link must not overrun it
        if (rxByteValid && !full) begin
          st_next.mem[st_reg.wrPtr[4:2]][wrLane] = rxByte;
          st_next.wrPtr = st_reg.wrPtr + 6'h01;
        end
        if (rxEnd) begin
          st_next.rxStat  = rxStatus;
          st_next.rxState = RX_PAD;
        end
      end
      RX_PAD: begin
        if ((st_reg.wrPtr & (unit - 6'h01)) == '0) begin
          st_next.rxState = RX_STAT;
        end else if (!full) begin
          st_next.mem[st_reg.wrPtr[4:2]][wrLane] = FILL_BYTE;
          st_next.wrPtr = st_reg.wrPtr + 6'h01;
        end
      end
      RX_STAT: begin
        if (count <= FIFO_BYTES - unit) begin
          if (dataWidthSelect)
            st_next.mem[st_reg.wrPtr[4:2]] = {16'h0000, st_reg.rxStat};
          else
            st_next.mem[st_reg.wrPtr[4:2]][{st_reg.wrPtr[1], 1'b0} +: 2] = st_reg.rxStat;
          st_next.wrPtr   = st_reg.wrPtr + unit;
          st_next.flush   = 1'b1;
          st_next.rxState = RX_DATA;
        end
      end
      default: st_next.rxState = RX_DATA;
    endcase
  end
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      st_reg      <= '0;
      st_reg.lfsr <= LFSR_SEED;
    end else begin
      st_reg <= st_next;
    end
  end
  // ==========================================================
  // outputs, all straight from the state register
  assign transmitBitClock = st_reg.txcPhase;
  assign txSerial         = st_reg.txSerial;
  assign txEnable         = st_reg.txEnable;
  assign txTake           = st_reg.txTake;
  assign txRewind         = st_reg.txRewind;
  assign txStatus         = st_reg.txStatus;
  assign rxDma            = st_reg.dma;
endmodule

`default_nettype wire

// *** tb/etrf_mac_sva.sv ***
// etrf_mac_sva: port checker for the mac block
`timescale 1ns/1ps
`default_nettype none
module etrf_mac_sva
  import etrf_pkg::*;
(
  // clock and reset
  input wire logic            clock,
  input wire logic            nrst,
  // watched ports
  input wire logic            dataWidthSelect,
  input wire logic            collision,
  input wire logic            transmitBitClock,
  input wire logic            txSerial,
  input wire logic            txEnable,
  input wire logic            txTake,
  input wire etrf_tx_status_t txStatus,
  input wire etrf_dma_out_t   rxDma
);
  logic [15:0] onLen_reg;
  logic [15:0] offLen_reg;
  logic        collSeen_reg;
  // ==========================================
  // run lengths; idle count saturates so long quiet spans stay legal
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      onLen_reg    <= 16'h0;
      offLen_reg   <= 16'hffff;
      collSeen_reg <= 1'b0;
    end else begin
      onLen_reg    <= txEnable ? onLen_reg + 16'h1 : 16'h0;
      offLen_reg   <= (txEnable) ? 16'h0 : (&offLen_reg ? offLen_reg : offLen_reg + 16'h1);
      collSeen_reg <= txEnable ? (collSeen_reg | collision) : 1'b0;
    end
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  bitclk_period_a: assert property ($rose(transmitBitClock) |=> transmitBitClock ##1
    !transmitBitClock ##1 !transmitBitClock ##1 transmitBitClock) else $error("bad bit clock");
  bit_hold_a: assert property (txEnable && $changed(txSerial) |=> $stable(txSerial) [*3])
    else $error("serial bit shorter than four clocks");
  pre_first_a: assert property ($rose(txEnable) |-> txSerial)
    else $error("frame does not open with a one");
  take_frame_a: assert property (txTake |-> txEnable) else $error("byte taken outside frame");
  coll_jam_a: assert property (collision && txEnable |-> ##[1:400] !txEnable)
    else $error("transmitter kept sending after collision");
  min_frag_a: assert property ($fell(txEnable) && collSeen_reg |-> onLen_reg >= 16'h0180)
    else $error("collision fragment too short");
  gap_before_a: assert property ($rose(txEnable) |-> offLen_reg >= 16'h0180)
    else $error("gap shorter than required");
  exc_coll_a: assert property (txStatus.done && txStatus.excessColl |->
    txStatus.collisions == 5'h10 && !txStatus.ok) else $error("bad abort status");
  good_done_a: assert property ($fell(txEnable) && !collSeen_reg |->
    ##[0:4] (txStatus.done && txStatus.ok)) else $error("no status after frame");
  w16_zero_a: assert property (rxDma.valid && !dataWidthSelect |-> rxDma.data[31:16] == 16'h0)
    else $error("upper lines used in narrow mode");
  last_ends_a: assert property (rxDma.last |-> rxDma.valid && !rxDma.req)
    else $error("burst end malformed");
  valid_req_a: assert property (rxDma.valid |-> $past(rxDma.req))
    else $error("data moved without request");
  cover property (collision && txEnable);
  cover property ($fell(txEnable) && !collSeen_reg);
  cover property (rxDma.last);
endmodule
bind etrf_mac etrf_mac_sva u_sva (.clock, .nrst, .dataWidthSelect, .collision, .transmitBitClock,
  .txSerial, .txEnable, .txTake, .txStatus, .rxDma);
`default_nettype wire

// *** tb/etrf_net_model.sv ***
// etrf_net_model: shared medium that hears the transmitter and forces collisions
`timescale 1ns/1ps
`default_nettype none
module etrf_net_model (
  // clock
  input  wire logic clock,
  // transmitter side
  input  wire logic txEnable,
  input  wire logic txSerial,
  // scenario control
  input  wire logic csReq,
  input  var  int   collAt,
  // to the transmitter
  output logic      carrierSense,
  output logic      collision
);
  logic bits [$];
  logic prev [$];
  logic enSeen = 1'b0;
  int   cnt = 0;
  int   collCnt = 0;
  // ==========================================
  // own frame is always heard back, foreign traffic only on request
  assign carrierSense = txEnable | csReq | collision;
  assign collision = (collCnt != 0);
  always @(posedge clock) begin
    if (txEnable) begin
      if (!enSeen) begin
        prev = bits;
        bits = {};
        cnt = 0;
      end else cnt++;
      if (cnt % 4 == 2) bits.push_back(txSerial);
    end
    enSeen = txEnable;
    if (collCnt != 0) collCnt <= collCnt - 1;
    else if (txEnable && bits.size() == collAt) collCnt <= 8;
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// testbench: directed frames and packets for the mac block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import etrf_pkg::*;
  // ==========================================
  // signals
  logic            clock = 1'b0;
  logic            nrst = 1'b0;
  logic            dataWidthSelect = 1'b1;
  logic            byteOrderSelect = 1'b0;
  logic            burstModeSelect = 1'b1;
  logic [1:0]      rxFifoThreshold = 2'h0;
  logic            crcInhibit = 1'b0;
  logic            carrierSense, collision, transmitBitClock, txSerial, txEnable;
  logic            txStart = 1'b0;
  logic [7:0]      txData;
  logic            txLast, txTake, txRewind;
  etrf_tx_status_t txStatus, st;
  logic            rxByteValid = 1'b0;
  logic [7:0]      rxByte = 8'h0;
  logic            rxEnd = 1'b0;
  logic [15:0]     rxStatus = 16'h0;
  logic            rxDmaGrant = 1'b0;
  etrf_dma_out_t   rxDma;
  logic            csReq = 1'b0;
  int              collAt = -1;
  logic [7:0]      frame [4] = '{8'h3c, 8'ha5, 8'h01, 8'h80};
  int              idx = 0, nBytes = 1, doneCnt = 0, t = 0, k;
  int              compares = 0, miscompares = 0;
  logic [31:0]     got [$];
  logic            e [$];
  always #12.5 clock = ~clock;
  assign txData = frame[idx[1:0]];
  assign txLast = (idx == nBytes - 1);
  etrf_mac u_dut (.clock, .nrst, .dataWidthSelect, .byteOrderSelect, .burstModeSelect,
    .rxFifoThreshold, .crcInhibit, .carrierSense, .collision, .transmitBitClock, .txSerial,
    .txEnable, .txStart, .txData, .txLast, .txTake, .txRewind, .txStatus, .rxByteValid,
    .rxByte, .rxEnd, .rxStatus, .rxDmaGrant, .rxDma);
  etrf_net_model u_net (.clock, .txEnable, .txSerial, .csReq, .collAt, .carrierSense,
    .collision);
  // byte source, status capture and dma sink; grant follows every request
  always @(negedge clock) begin
    if (txRewind === 1'b1) idx = 0;
    else if (txTake === 1'b1) idx++;
    if (txStatus.done === 1'b1) begin
      st = txStatus;
      doneCnt++;
    end
    rxDmaGrant = rxDma.req;
    if (rxDma.valid === 1'b1) got.push_back(rxDma.data);
  end
  // ==========================================
  // tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic push(input logic [7:0] b);
    for (int i = 0; i < 8; i++) e.push_back(b[i]);
  endtask
  task automatic send(input int n, input logic inh, input int coll, input int csAt);
    int          d;
    logic [31:0] crc;
    d = doneCnt;
    e = {};
    crc = CRC_INIT;
    for (int i = 0; i < 7; i++) push(8'h55);
    push(8'hd5);
    for (int i = 0; i < n; i++) begin
      push(frame[i]);
      for (int j = 0; j < 8; j++) crc = (crc >> 1) ^ ((crc[0] ^ frame[i][j]) ? CRC_POLY : 32'h0);
    end
    crc = ~crc;
    if (!inh) for (int j = 0; j < 32; j++) e.push_back(crc[j]);
    idx = 0;
    nBytes = n;
    crcInhibit = inh;
    collAt = coll;
    txStart = 1'b1;
    @(negedge clock);
    txStart = 1'b0;
    t = 0;
    for (int i = 1; i < 30000 && doneCnt == d; i++) begin
      @(negedge clock);
      csReq = (i == csAt);
      if (collision === 1'b1) collAt = -1;
      if (t == 0 && txEnable === 1'b1) t = i;
    end
    chk(doneCnt - d, 1);
    chk(u_net.bits.size(), e.size());
    for (int i = 0; i < e.size(); i++) chk(u_net.bits[i], e[i]);
    chk({st.ok, st.excessColl}, 2'b10);
  endtask
  task automatic jam_ones;
    k = 0;
    for (int i = u_net.prev.size() - 32; i < u_net.prev.size(); i++) k += u_net.prev[i];
    chk(k, 32);
  endtask
  task automatic rx_run(input int n, input logic [15:0] s, input logic [31:0] x [$]);
    got = {};
    for (int i = 0; i < n; i++) begin
      rxByteValid = 1'b1;
      rxByte = 8'h10 + 8'(i);
      @(negedge clock);
    end
    rxByteValid = 1'b0;
    rxEnd = 1'b1;
    rxStatus = s;
    @(negedge clock);
    rxEnd = 1'b0;
    for (int i = 0; i < 300 && (got.size() < x.size() || rxDma.req); i++) @(negedge clock);
    chk(got.size(), x.size());
    foreach (x[i]) chk(got[i], x[i]);
  endtask
  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================
  // sequence
  initial begin
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    send(2, 1'b0, -1, -1);
    chk(t >= 383 && t <= 392, 1);
    send(1, 1'b1, -1, -1);
    send(4, 1'b0, -1, 100);
    chk(t >= 480 && t <= 495, 1);
    send(1, 1'b0, -1, 300);
    chk(t >= 383 && t <= 392, 1);
    send(2, 1'b0, 10, -1);
    chk(u_net.prev.size(), 96);
    chk(st.collisions, 1);
    jam_ones();
    send(3, 1'b0, 70, -1);
    chk(u_net.prev.size() >= 101 && u_net.prev.size() <= 105, 1);
    jam_ones();
    rx_run(6, 16'h1234, '{32'h13121110, 32'hffff1514, 32'h00001234});
    dataWidthSelect = 1'b0;
    byteOrderSelect = 1'b1;
    burstModeSelect = 1'b0;
    rxFifoThreshold = 2'h3;
    repeat (2) @(negedge clock);
    // five bytes leave the pointers long-word aligned for the later 32-bit run
    rx_run(5, 16'habcd, '{32'h00001011, 32'h00001213, 32'h000014ff, 32'h0000abcd});
    dataWidthSelect = 1'b1;
    burstModeSelect = 1'b1;
    rxFifoThreshold = 2'h0;
    repeat (2) @(negedge clock);
    rx_run(9, 16'h5a5a, '{32'h10111213, 32'h14151617, 32'h18ffffff, 32'h00005a5a});
    final_report();
  end
  // cut a hang short well after the longest expected run
  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
